// ==== hw/ash_map.svh ====
// Constants for the auxiliary sensor bus hub
`ifndef ASH_MAP_SVH
`define ASH_MAP_SVH

// Timing
`define ASH_CLK_PERIOD_NS 100
`define ASH_SCL_PERIOD_NS 10000
`define ASH_QTR_CYC ((`ASH_SCL_PERIOD_NS) / (4 * `ASH_CLK_PERIOD_NS))

// Channel layout
`define ASH_NCH 5
`define ASH_BULK_NCH 4
`define ASH_SINGLE_CH 4
`define ASH_MAX_BYTES 24
`define ASH_LEN_W 4

// Primary slave address upper bits, value arbitrary
`define ASH_SLV_ADDR_BASE 7'h2a

// Address byte direction bit
`define ASH_DIR_WR 1'b0
`define ASH_DIR_RD 1'b1

`endif

// ==== hw/ash_pkg.sv ====
// Types for the auxiliary sensor bus hub
package ash_pkg;

	typedef enum logic [1:0] {
		ASH_CMD_START,
		ASH_CMD_WRITE,
		ASH_CMD_READ,
		ASH_CMD_STOP
	} ash_cmd_t;

	typedef enum logic [1:0] {
		ASH_E_IDLE,
		ASH_E_START,
		ASH_E_BIT,
		ASH_E_STOP
	} ash_eng_st_t;

	typedef struct packed {
		ash_eng_st_t st;
		logic [1:0]  ph;
		logic [7:0]  cnt;
		logic [3:0]  bitn;
		logic [8:0]  sh;
		logic [8:0]  rin;
		logic        scl_oe;
		logic        sda_oe;
		logic        done;
		logic        nack;
		logic [7:0]  rx;
	} ash_eng_t;

	typedef enum logic [3:0] {
		ASH_H_IDLE,
		ASH_H_NEXT,
		ASH_H_START,
		ASH_H_ADDR_WR,
		ASH_H_REG,
		ASH_H_WDATA,
		ASH_H_RESTART,
		ASH_H_ADDR_RD,
		ASH_H_READ,
		ASH_H_STOP
	} ash_hub_st_t;

	typedef struct packed {
		ash_hub_st_t      st;
		logic [2:0]       ch;
		logic [4:0]       nb;
		logic [4:0]       ptr;
		logic             issued;
		logic             ad0_m;
		logic             ad0_s;
		logic             scl_m;
		logic             scl_s;
		logic             sda_m;
		logic             sda_s;
		logic [23:0][7:0] ext;
		logic             push;
		logic [7:0]       push_data;
		logic             nack_evt;
		logic             single_done;
		logic [7:0]       single_rx;
	} ash_hub_t;

endpackage

// ==== hw/ash_i2c_byte.sv ====
// Byte-level open-drain I2C master engine
`timescale 1ns/100ps
`default_nettype none
`include "ash_map.svh"

module ash_i2c_byte (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	// Command
	input  wire logic           cmd_valid_i,
	input  wire ash_pkg::ash_cmd_t cmd_i,
	input  wire logic [7:0]     tx_i,
	input  wire logic           ack_i,
	output logic                done_o,
	output logic                nack_o,
	output logic [7:0]          rx_o,
	// Synchronised bus levels
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	// Open-drain drive, high pulls the line low
	output logic                scl_oe_o,
	output logic                sda_oe_o
);

	localparam logic [7:0] QTR = 8'(`ASH_QTR_CYC - 1);

	ash_pkg::ash_eng_t q;
	ash_pkg::ash_eng_t d;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			ash_pkg::ASH_E_IDLE:
			begin
				d.ph = 2'd0;
				d.cnt = QTR;
				d.bitn = 4'd0;
				if (cmd_valid_i)
				begin
					case (cmd_i)
						ash_pkg::ASH_CMD_START:
						begin
							d.st = ash_pkg::ASH_E_START;
							d.sda_oe = 1'b0;
						end
						ash_pkg::ASH_CMD_WRITE:
						begin
							// Ack slot released so the slave can answer
							d.st = ash_pkg::ASH_E_BIT;
							d.sh = {tx_i, 1'b1};
							d.sda_oe = ~tx_i[7];
						end
						ash_pkg::ASH_CMD_READ:
						begin
							d.st = ash_pkg::ASH_E_BIT;
							d.sh = {8'hff, ~ack_i};
							d.sda_oe = 1'b0;
						end
						default:
						begin
							d.st = ash_pkg::ASH_E_STOP;
							d.sda_oe = 1'b1;
						end
					endcase
				end
			end
			default:
			begin
				if (q.cnt != 8'd0)
				begin
					d.cnt = q.cnt - 8'd1;
				end
				// Clock stretching: phase 1 holds until the line is high
				else if (q.ph != 2'd1 || scl_i)
				begin
					d.cnt = QTR;
					d.ph = q.ph + 2'd1;
					case (q.st)
						ash_pkg::ASH_E_START:
						begin
							case (q.ph)
								2'd0: d.scl_oe = 1'b0;
								2'd1: d.sda_oe = 1'b1;
								default:
								begin
									d.scl_oe = 1'b1;
									d.done = 1'b1;
									d.st = ash_pkg::ASH_E_IDLE;
								end
							endcase
						end
						ash_pkg::ASH_E_BIT:
						begin
							case (q.ph)
								2'd0: d.scl_oe = 1'b0;
								2'd1: d.rin = {q.rin[7:0], sda_i};
								default:
								begin
									d.scl_oe = 1'b1;
									d.sh = {q.sh[7:0], 1'b1};
									d.ph = 2'd0;
									if (q.bitn == 4'd8)
									begin
										d.rx = q.rin[8:1];
										d.nack = q.rin[0];
										d.done = 1'b1;
										d.st = ash_pkg::ASH_E_IDLE;
									end
									else
									begin
										d.bitn = q.bitn + 4'd1;
										d.sda_oe = ~q.sh[7];
									end
								end
							endcase
						end
						default:
						begin
							case (q.ph)
								2'd0: d.scl_oe = 1'b0;
								2'd1: d.sda_oe = 1'b1;
								default:
								begin
									d.sda_oe = 1'b0;
									d.done = 1'b1;
									d.st = ash_pkg::ASH_E_IDLE;
								end
							endcase
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= d;
	end

	assign done_o   = q.done;
	assign nack_o   = q.nack;
	assign rx_o     = q.rx;
	assign scl_oe_o = q.scl_oe;
	assign sda_oe_o = q.sda_oe;

endmodule
`default_nettype wire

// ==== hw/ash_hub.sv ====
// Auxiliary sensor bus hub: bypass switch and channel sequencer
// Function
// (RL1) Device is only ever a slave to the host, SPI or I2C.
// (RL2) Primary slave address LSB follows the address-select pin.
// (RL3) Bypass switch joins primary SDA/SCL to the sensor bus lines.
// (RL4) Host configures sensors, then turns bypass off for the master.
// (RL5) Bypass off: internal master owns sensor bus and gathers data.
// (RL6) In SPI mode the bypass path is never usable.
// (RL7) Channels 0-4 read or write any sensor address and register.
// (RL8) Channel 4 does single-byte reads and writes only.
// (RL9) Master supports single-byte and multi-byte reads.
// (RL10) Channel 0-3 read data lands in sensor registers, optional FIFO push.
// (RL11) Sensor bus is in exactly one mode: master or pass-through.
// (RL12) In master mode the device masters every sensor on the bus.
// (RL13) Up to 24 bytes from up to 4 sensors per acquisition cycle.
// (RL14) Missing acknowledge from a sensor raises an event.
// (RL15) Enabled channels are served in ascending order each cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ash_map.svh"

module ash_hub #(
	parameter int NCH   = `ASH_NCH,
	parameter int LEN_W = `ASH_LEN_W
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// Primary port mode and address strap
	input  wire logic                 spi_mode_i,
	input  wire logic                 address_select_pin_i,
	output logic [6:0]                slave_addr_o,
	// Bypass control
	input  wire logic                 bypass_en_i,
	output logic                      bypass_switch_on_o,
	// Acquisition
	input  wire logic                 acq_start_i,
	output logic                      busy_o,
	// Channel configuration, channel n in slice n
	input  wire logic [NCH-1:0]       ch_en_i,
	input  wire logic [NCH-1:0]       ch_rnw_i,
	input  wire logic [NCH-2:0]       ch_fifo_en_i,
	input  wire logic [NCH*7-1:0]     ch_dev_i,
	input  wire logic [NCH*8-1:0]     ch_reg_i,
	input  wire logic [NCH*8-1:0]     ch_wdata_i,
	input  wire logic [(NCH-1)*LEN_W-1:0] ch_len_i,
	// Results
	output logic [`ASH_MAX_BYTES*8-1:0] ext_sensor_data_o,
	output logic                      fifo_push_o,
	output logic [7:0]                fifo_data_o,
	output logic                      single_done_o,
	output logic [7:0]                single_rx_o,
	output logic                      aux_nack_o,
	// Sensor bus pins
	input  wire logic                 sensor_bus_clock_line_i,
	output logic                      sensor_bus_clock_line_o,
	output logic                      sensor_bus_clock_line_oe_o,
	input  wire logic                 sensor_bus_data_line_i,
	output logic                      sensor_bus_data_line_o,
	output logic                      sensor_bus_data_line_oe_o
);

	ash_pkg::ash_hub_t q;
	ash_pkg::ash_hub_t d;

	logic              eng_valid;
	ash_pkg::ash_cmd_t eng_cmd;
	logic [7:0]        eng_tx;
	logic              eng_ack;
	logic              eng_done;
	logic              eng_nack;
	logic [7:0]        eng_rx;
	logic              eng_scl_oe;
	logic              eng_sda_oe;
	logic              bypass_on;
	logic [6:0]        cur_dev;
	logic [7:0]        cur_reg;
	logic [7:0]        cur_wdata;
	logic              cur_rnw;
	logic              single;
	logic [4:0]        room;
	logic [4:0]        want;

	ash_i2c_byte u_eng (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.cmd_valid_i(eng_valid),
		.cmd_i      (eng_cmd),
		.tx_i       (eng_tx),
		.ack_i      (eng_ack),
		.done_o     (eng_done),
		.nack_o     (eng_nack),
		.rx_o       (eng_rx),
		.scl_i      (q.scl_s),
		.sda_i      (q.sda_s),
		.scl_oe_o   (eng_scl_oe),
		.sda_oe_o   (eng_sda_oe)
	);

	// (RL6) No bypass in SPI mode
	// (RL11) Switch only closes while the master is idle
	// A frame is never cut: a bypass request waits for the sequencer
	assign bypass_on = bypass_en_i && !spi_mode_i
		&& q.st == ash_pkg::ASH_H_IDLE;

	assign cur_dev   = ch_dev_i[q.ch*7 +: 7];
	assign cur_reg   = ch_reg_i[q.ch*8 +: 8];
	assign cur_wdata = ch_wdata_i[q.ch*8 +: 8];
	assign cur_rnw   = ch_rnw_i[q.ch];
	assign single    = q.ch == 3'(`ASH_SINGLE_CH);
	assign room      = 5'(`ASH_MAX_BYTES) - q.ptr;

	// (RL13) Bulk reads are clipped to what is left of the 24 bytes
	always_comb
	begin
		want = 5'd0;
		if (!single)
			want = 5'(ch_len_i[q.ch*LEN_W +: LEN_W]);
		if (want > room)
			want = room;
	end

	// Command for the current state
	always_comb
	begin
		eng_cmd = ash_pkg::ASH_CMD_START;
		eng_tx  = 8'h00;
		eng_ack = 1'b0;
		case (q.st)
			ash_pkg::ASH_H_ADDR_WR:
			begin
				eng_cmd = ash_pkg::ASH_CMD_WRITE;
				eng_tx  = {cur_dev, `ASH_DIR_WR};
			end
			ash_pkg::ASH_H_REG:
			begin
				eng_cmd = ash_pkg::ASH_CMD_WRITE;
				eng_tx  = cur_reg;
			end
			ash_pkg::ASH_H_WDATA:
			begin
				eng_cmd = ash_pkg::ASH_CMD_WRITE;
				eng_tx  = cur_wdata;
			end
			ash_pkg::ASH_H_ADDR_RD:
			begin
				eng_cmd = ash_pkg::ASH_CMD_WRITE;
				eng_tx  = {cur_dev, `ASH_DIR_RD};
			end
			ash_pkg::ASH_H_READ:
			begin
				// (RL9) Ack every byte but the last of a burst
				eng_cmd = ash_pkg::ASH_CMD_READ;
				eng_ack = q.nb != 5'd1;
			end
			ash_pkg::ASH_H_STOP:
				eng_cmd = ash_pkg::ASH_CMD_STOP;
			default:
				eng_cmd = ash_pkg::ASH_CMD_START;
		endcase
	end

	// Launch once per state, once per byte in READ; issued stops a relaunch before done returns
	assign eng_valid = !q.issued && q.st != ash_pkg::ASH_H_IDLE
		&& q.st != ash_pkg::ASH_H_NEXT;

	always_comb
	begin
		d = q;
		d.push = 1'b0;
		d.nack_evt = 1'b0;
		d.single_done = 1'b0;
		// Two-flop synchronisers: strap and sensor lines are asynchronous
		d.ad0_m = address_select_pin_i;
		d.ad0_s = q.ad0_m;
		d.scl_m = sensor_bus_clock_line_i;
		d.scl_s = q.scl_m;
		d.sda_m = sensor_bus_data_line_i;
		d.sda_s = q.sda_m;
		if (eng_valid)
			d.issued = 1'b1;
		case (q.st)
			ash_pkg::ASH_H_IDLE:
			begin
				// (RL4) A start is ignored while the bypass switch is on
				if (acq_start_i && !bypass_on)
				begin
					d.ch = 3'd0;
					d.ptr = 5'd0;
					d.st = ash_pkg::ASH_H_NEXT;
				end
			end
			ash_pkg::ASH_H_NEXT:
			begin
				// (RL15) Ascending channel walk
				if (q.ch == 3'(NCH))
					d.st = ash_pkg::ASH_H_IDLE;
				// Zero-length or clipped-away reads never touch the bus
				else if (!ch_en_i[q.ch] || (cur_rnw && !single
					&& want == 5'd0))
					d.ch = q.ch + 3'd1;
				else
				begin
					// (RL8) Channel 4 moves exactly one byte
					d.nb = single ? 5'd1 : want;
					d.st = ash_pkg::ASH_H_START;
				end
			end
			default:
			begin
				if (q.issued && eng_done)
				begin
					d.issued = 1'b0;
					case (q.st)
						ash_pkg::ASH_H_START:
							d.st = ash_pkg::ASH_H_ADDR_WR;
						ash_pkg::ASH_H_RESTART:
							d.st = ash_pkg::ASH_H_ADDR_RD;
						ash_pkg::ASH_H_READ:
						begin
							// (RL10) Bulk channels fill sensor registers
							if (!single)
							begin
								// Pointer restarts each cycle, bytes follow channels
								d.ext[q.ptr] = eng_rx;
								d.ptr = q.ptr + 5'd1;
								d.push = ch_fifo_en_i[q.ch[1:0]];
								d.push_data = eng_rx;
							end
							else
								d.single_rx = eng_rx;
							d.nb = q.nb - 5'd1;
							if (q.nb == 5'd1)
								d.st = ash_pkg::ASH_H_STOP;
						end
						ash_pkg::ASH_H_STOP:
						begin
							d.single_done = single;
							d.ch = q.ch + 3'd1;
							d.st = ash_pkg::ASH_H_NEXT;
						end
						default:
						begin
							// (RL14) Unanswered byte aborts the channel
							if (eng_nack)
							begin
								d.nack_evt = 1'b1;
								d.st = ash_pkg::ASH_H_STOP;
							end
							// (RL7) Register write or read of any device
							else if (q.st == ash_pkg::ASH_H_ADDR_WR)
								d.st = ash_pkg::ASH_H_REG;
							else if (q.st == ash_pkg::ASH_H_REG)
								d.st = cur_rnw ? ash_pkg::ASH_H_RESTART
									: ash_pkg::ASH_H_WDATA;
							else if (q.st == ash_pkg::ASH_H_ADDR_RD)
								d.st = ash_pkg::ASH_H_READ;
							else
								d.st = ash_pkg::ASH_H_STOP;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= d;
	end

	// Upper six bits of the base are fixed, the strap supplies bit 0
	localparam logic [5:0] ADDR_HI = 6'(`ASH_SLV_ADDR_BASE >> 1);

	// (RL1) Primary side only answers as a slave
	// (RL2) Address LSB from the strap pin
	assign slave_addr_o = {ADDR_HI, q.ad0_s};

	// (RL3) Analog switch enable, the master lets go of the lines
	assign bypass_switch_on_o = bypass_on;
	// Config inputs must hold still until busy drops
	assign busy_o             = q.st != ash_pkg::ASH_H_IDLE;

	// (RL5) Master drives only while bypass is off
	// (RL12) Open drain drive toward every sensor
	assign sensor_bus_clock_line_o    = 1'b0;
	assign sensor_bus_data_line_o     = 1'b0;
	assign sensor_bus_clock_line_oe_o = eng_scl_oe && !bypass_on;
	assign sensor_bus_data_line_oe_o  = eng_sda_oe && !bypass_on;

	// Sensor bytes hold until the next acquisition overwrites them
	assign ext_sensor_data_o = q.ext;
	assign fifo_push_o       = q.push;
	assign fifo_data_o       = q.push_data;
	assign single_done_o     = q.single_done;
	assign single_rx_o       = q.single_rx;
	assign aux_nack_o        = q.nack_evt;

endmodule
`default_nettype wire

// ==== verification/ash_hub_asserts.sv ====
// Port checker for the sensor bus hub
`timescale 1ns/100ps
`default_nettype none
module ash_hub_asserts (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rstn_i,
	// Host side
	input wire logic       spi_mode_i,
	input wire logic       address_select_pin_i,
	input wire logic [6:0] slave_addr_o,
	input wire logic       bypass_en_i,
	input wire logic       bypass_switch_on_o,
	input wire logic       acq_start_i,
	input wire logic       busy_o,
	input wire logic       fifo_push_o,
	input wire logic       single_done_o,
	input wire logic       aux_nack_o,
	// Sensor bus drive
	input wire logic       sensor_bus_clock_line_o,
	input wire logic       sensor_bus_clock_line_oe_o,
	input wire logic       sensor_bus_data_line_o,
	input wire logic       sensor_bus_data_line_oe_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_addr_strap: assert property (
		$stable(address_select_pin_i) [*4]
		|-> slave_addr_o[0] == address_select_pin_i)
		else $error("address bit does not follow strap");
	a_bypass_follow: assert property (
		!busy_o |-> bypass_switch_on_o == (bypass_en_i && !spi_mode_i))
		else $error("bypass switch wrong while idle");
	a_bypass_held: assert property (
		busy_o |-> !bypass_switch_on_o)
		else $error("bypass closed while master busy");
	a_spi_no_bypass: assert property (
		spi_mode_i |-> !bypass_switch_on_o)
		else $error("bypass closed in spi mode");
	a_pass_quiet: assert property (
		bypass_switch_on_o
		|-> !sensor_bus_clock_line_oe_o && !sensor_bus_data_line_oe_o)
		else $error("master drives bus in pass-through");
	a_acq_taken: assert property (
		acq_start_i && !busy_o && !bypass_switch_on_o |=> busy_o)
		else $error("acquisition start not taken");
	a_acq_refused: assert property (
		acq_start_i && !busy_o && bypass_switch_on_o |=> !busy_o)
		else $error("acquisition started in pass-through");
	a_drain_only: assert property (
		!sensor_bus_clock_line_o && !sensor_bus_data_line_o)
		else $error("sensor bus driven high");
	a_idle_release: assert property (
		!busy_o |-> !sensor_bus_clock_line_oe_o)
		else $error("clock line held while idle");
	a_push_pulse: assert property (
		fifo_push_o |-> busy_o ##1 !fifo_push_o)
		else $error("fifo push not a busy pulse");
	a_nack_pulse: assert property (
		aux_nack_o |-> busy_o ##1 !aux_nack_o)
		else $error("nack event not a busy pulse");
	a_single_pulse: assert property (
		single_done_o |=> !single_done_o)
		else $error("single done longer than a cycle");
	a_busy_runs: assert property (
		$rose(busy_o) |-> busy_o [*6])
		else $error("acquisition ended too soon");

	c_push: cover property (fifo_push_o);
	c_nack: cover property (aux_nack_o);
	c_single: cover property (single_done_o);
	c_refused: cover property (acq_start_i && bypass_switch_on_o);
endmodule

bind ash_hub ash_hub_asserts u_chk (
	.clk_i,
	.rstn_i,
	.spi_mode_i,
	.address_select_pin_i,
	.slave_addr_o,
	.bypass_en_i,
	.bypass_switch_on_o,
	.acq_start_i,
	.busy_o,
	.fifo_push_o,
	.single_done_o,
	.aux_nack_o,
	.sensor_bus_clock_line_o,
	.sensor_bus_clock_line_oe_o,
	.sensor_bus_data_line_o,
	.sensor_bus_data_line_oe_o
);
`default_nettype wire

// ==== verification/ash_sensor_model.sv ====
// Behavioural register-file sensor on the auxiliary bus
`timescale 1ns/100ps
`default_nettype none
module ash_sensor_model #(
	parameter logic [6:0] NO_ACK_DEV = 7'h77
) (
	// Bus levels and drive
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  var  int   stretch_ns_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	logic [7:0] mem [256];
	logic [7:0] ptr;
	int         go_n;
	int         seen;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = ~8'(i);
		scl_oe_o = 0;
		sda_oe_o = 0;
		go_n = 0;
		seen = 0;
	end

	task automatic get(output logic [7:0] b);
		repeat (8)
		begin
			@(posedge scl_i);
			b = {b[6:0], sda_i};
		end
		@(negedge scl_i);
	endtask

	// Stretching proves the master waits out a slow sensor
	task automatic ack;
		#200 sda_oe_o = 1;
		scl_oe_o = stretch_ns_i > 0;
		#(stretch_ns_i) scl_oe_o = 0;
		@(negedge scl_i);
		#200 sda_oe_o = 0;
	endtask

	task automatic put(input logic [7:0] b, output logic m);
		for (int i = 7; i >= 0; i--)
		begin
			#200 sda_oe_o = !b[i];
			@(negedge scl_i);
		end
		#200 sda_oe_o = 0;
		@(posedge scl_i);
		m = !sda_i;
		@(negedge scl_i);
	endtask

	task automatic serve;
		logic [7:0] b;
		logic       m;
		get(b);
		if (b[7:1] == NO_ACK_DEV)
			return;
		ack();
		if (b[0])
		begin
			do
			begin
				put(mem[ptr], m);
				ptr++;
			end while (m);
		end
		else
		begin
			get(ptr);
			ack();
			forever
			begin
				get(b);
				ack();
				mem[ptr] = b;
				ptr++;
			end
		end
	endtask

	// Data may move in the step in which the clock falls; look again
	// a moment later so that this is not taken for a start or a stop
	always @(negedge sda_i)
		#1 if (scl_i)
		begin
			disable worker;
			sda_oe_o = 0;
			scl_oe_o = 0;
			go_n++;
		end

	always @(posedge sda_i)
		#1 if (scl_i)
		begin
			disable worker;
			sda_oe_o = 0;
			scl_oe_o = 0;
		end

	always
	begin : worker
		wait (go_n != seen);
		seen = go_n;
		serve();
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the sensor bus hub
`timescale 1ns/100ps
`default_nettype none
`include "ash_map.svh"
module tb;
	`define CHK(n, e, s) chk(n, (e), (s))
	localparam logic [6:0] BAD = 7'h77;
	logic         clk_i, rstn_i, spi, pin, byp, acq;
	logic [4:0]   en, rnw;
	logic [3:0]   fen;
	logic [34:0]  dev;
	logic [39:0]  rg, wd;
	logic [15:0]  len;
	logic [191:0] ext;
	logic [6:0]   sa;
	logic [7:0]   fdat, srx;
	logic         sw, busy, push, sdone, nack;
	logic         scl_oe, sda_oe, m_scl_oe, m_sda_oe;
	wire logic    scl = !(scl_oe | m_scl_oe);
	wire logic    sda = !(sda_oe | m_sda_oe);
	int           stretch, bad_count, comparisons, nk, sd;
	logic [7:0]   shadow [256];
	logic [7:0]   fq [$];

	ash_hub uut (.clk_i(clk_i), .rstn_i(rstn_i), .spi_mode_i(spi),
		.address_select_pin_i(pin), .slave_addr_o(sa), .bypass_en_i(byp),
		.bypass_switch_on_o(sw), .acq_start_i(acq), .busy_o(busy),
		.ch_en_i(en), .ch_rnw_i(rnw), .ch_fifo_en_i(fen), .ch_dev_i(dev),
		.ch_reg_i(rg), .ch_wdata_i(wd), .ch_len_i(len),
		.ext_sensor_data_o(ext), .fifo_push_o(push), .fifo_data_o(fdat),
		.single_done_o(sdone), .single_rx_o(srx), .aux_nack_o(nack),
		.sensor_bus_clock_line_i(scl), .sensor_bus_clock_line_o(),
		.sensor_bus_clock_line_oe_o(m_scl_oe),
		.sensor_bus_data_line_i(sda), .sensor_bus_data_line_o(),
		.sensor_bus_data_line_oe_o(m_sda_oe));
	ash_sensor_model #(.NO_ACK_DEV(BAD)) sens (.scl_i(scl), .sda_i(sda),
		.stretch_ns_i(stretch), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));

	initial
	begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		if (push === 1'b1)
			fq.push_back(fdat);
		nk += (nack === 1'b1);
		sd += (sdone === 1'b1);
	end

	task automatic chk(input string n, input logic [191:0] e, s);
		comparisons++;
		if (e !== s)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cfg(int c, logic e, r, f, logic [6:0] d, logic [7:0] a,
		logic [3:0] n);
		en[c] <= e;
		rnw[c] <= r;
		dev[7*c+:7] <= d;
		rg[8*c+:8] <= a;
		wd[8*c+:8] <= 8'($urandom);
		if (c < 4)
		begin
			fen[c] <= f;
			len[4*c+:4] <= n;
		end
	endtask

	task automatic run(input string name, input int str);
		logic [7:0] xe [$];
		logic [7:0] xf [$];
		logic [7:0] xs;
		int         xn, w;
		@(posedge clk_i);
		xn = 0;
		xs = 0;
		for (int c = 0; c < 5; c++)
			if (en[c] && dev[7*c+:7] == BAD)
				xn++;
			else if (en[c] && !rnw[c])
				shadow[rg[8*c+:8]] = wd[8*c+:8];
			else if (en[c] && c == 4)
				xs = shadow[rg[32+:8]];
			else if (en[c])
				for (int i = 0; i < len[4*c+:4]; i++)
					if (xe.size() < `ASH_MAX_BYTES)
					begin
						xe.push_back(shadow[8'(rg[8*c+:8] + i)]);
						if (fen[c])
							xf.push_back(xe[$]);
					end
		fq.delete();
		nk = 0;
		sd = 0;
		stretch = str;
		acq <= 1;
		@(posedge clk_i);
		acq <= 0;
		#1 `CHK("busy", 1'b1, busy);
		for (w = 0; w < 60000 && busy !== 1'b0; w++)
			@(posedge clk_i);
		if (w == 60000)
		begin
			bad_count++;
			conclude();
		end
		@(posedge clk_i);
		foreach (xe[k]) `CHK("ext byte", xe[k], ext[8*k+:8]);
		`CHK("fifo count", xf.size(), fq.size());
		foreach (xf[k]) `CHK("fifo byte", xf[k], fq[k]);
		`CHK("nack count", xn, nk);
		`CHK("single done", en[4], sd);
		if (en[4] && rnw[4]) `CHK("single rx", xs, srx);
		$display("test %s done", name);
	endtask

	initial
	begin
		{rstn_i, spi, pin, byp, acq, en, rnw, fen, dev, rg, wd, len} = 0;
		{stretch, bad_count, comparisons, nk, sd} = 0;
		for (int i = 0; i < 256; i++)
			shadow[i] = ~8'(i);
		void'($urandom(47));
		repeat (5) @(posedge clk_i);
		rstn_i <= 1;
		pin <= 1'($urandom);
		repeat (4) @(posedge clk_i);
		#1 `CHK("slave addr", (`ASH_SLV_ADDR_BASE & 7'h7e) | pin, sa);
		$display("test strap done");
		@(posedge clk_i);
		// Write then read back the same register in one cycle
		cfg(0, 1, 0, 0, 7'h1e, 8'h40, 0);
		cfg(1, 1, 1, 1, 7'h1e, 8'h40, 3);
		cfg(2, 1, 1, 1, BAD, 8'($urandom), 2);
		cfg(3, 1, 1, 0, 7'h0c, 8'($urandom), 4'(1 + $urandom % 4));
		cfg(4, 1, 1, 0, 7'h1e, 8'h40, 0);
		run("mixed", 0);
		@(posedge clk_i);
		byp <= 1;
		acq <= 1;
		@(posedge clk_i);
		acq <= 0;
		#1 `CHK("bypass on", 1'b1, sw);
		@(posedge clk_i);
		#1 `CHK("busy refused", 1'b0, busy);
		@(posedge clk_i);
		spi <= 1;
		@(posedge clk_i);
		#1 `CHK("bypass spi", 1'b0, sw);
		@(posedge clk_i);
		cfg(0, 1, 1, 0, 7'h1e, 8'($urandom), 15);
		cfg(1, 1, 1, 0, 7'h0c, 8'($urandom), 15);
		cfg(2, 0, 1, 0, 7'h1e, 0, 0);
		cfg(3, 1, 1, 0, 7'h1e, 0, 0);
		cfg(4, 1, 0, 0, 7'h0c, 8'($urandom), 0);
		run("cap", 3000);
		`CHK("single write", wd[32+:8], sens.mem[rg[32+:8]]);
		conclude();
	end
endmodule
`default_nettype wire
